//--- common/sdc_pkg.sv
// Shared constants for the serial diagnosis command decoder.
`default_nettype none
package sdc_pkg;
    // Frame geometry.
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] LAST_BIT = 5'h0F;
    localparam logic [4:0] FIRST_BYTE_LAST = 5'h07;
    localparam logic [4:0] SECOND_BYTE_START = 5'h08;
    localparam int PIN_COUNT = 10;
    localparam int CHANNELS = 10;
    localparam int BANK_A_CHANNELS = 6;
    // Command set select in frame bits 14..12.
    localparam logic [2:0] SET_CTRL = 3'h0;
    localparam logic [2:0] SET_DCC = 3'h1;
    // Group-A codes in bits 3..0.
    localparam logic [3:0] GA_NOP = 4'h0;
    localparam logic [3:0] GA_SHORT_DIAG = 4'h1;
    localparam logic [3:0] GA_SHORT_DIAG_STATUS = 4'h2;
    localparam logic [3:0] GA_PATTERN_CHECK = 4'h4;
    localparam logic [3:0] GA_INPUT_PIN_READBACK = 4'h8;
    // Diagnosis and combined command set, bits 11..0.
    localparam logic [11:0] DIAG_BANK_A_READ = 12'h500;
    localparam logic [11:0] DIAG_BANK_B_READ = 12'h600;
    localparam logic [11:0] DIAG_BANK_A_CLEAR = 12'h100;
    localparam logic [11:0] DIAG_BANK_B_CLEAR = 12'h200;
    localparam int BIT_COMBINED = 11;
    localparam logic [2:0] MODE_SELECT_CLEAR_ALL = 3'h0;
    localparam logic [2:0] MODE_SELECT_SET_ONE = 3'h3;
    localparam logic [2:0] MODE_SELECT_SET_TWO = 3'h5;
    localparam logic [2:0] MODE_SELECT_SET_THREE = 3'h6;
    // Answer words.
    localparam logic [2:0] BANK_ANSWER_ID = 3'h1;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [1:0] FIELD_NO_ERROR = 2'h3;
    localparam logic [1:0] FIELD_OVERLOAD = 2'h2;
    // Idle times in ns and their cycle counts at the system clock rate.
    localparam int CLK_MHZ = 125;
    localparam int DIAG_IDLE_NS = 2000;
    localparam int OVERCURRENT_CLEAR_HOLDOFF_NS = 5000;
    localparam logic [15:0] DIAG_IDLE_CYC = 16'((DIAG_IDLE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] OC_HOLDOFF_CYC = 16'((OVERCURRENT_CLEAR_HOLDOFF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : sdc_pkg
`default_nettype wire

//--- logic/sdc_spi_diag_cmd_decoder.sv
// Serial command decoder for input pin readback, diagnosis banks and combined commands.
// What this block does
// RULE_01 - Pin readback answer: ten pins, zeros, parity.
// RULE_02 - Pins sampled at answering frame's chip-select fall.
// RULE_03 - Pin bit one when high, zero when low.
// RULE_04 - Readback answer prepared at command frame end.
// RULE_05 - Unknown pattern ignored and flags communication error.
// RULE_06 - Detected channel fault latched into its field.
// RULE_07 - Reading a bank never changes it.
// RULE_08 - Clear wipes the whole addressed bank.
// RULE_09 - Clear acts after idle time from select rise.
// RULE_10 - Overcurrent entry kept until holdoff time elapsed.
// RULE_11 - Pattern 0101 zeros reads bank A next frame.
// RULE_12 - Pattern 0110 zeros reads bank B next frame.
// RULE_13 - Bank A clear returns old contents, keeps faults.
// RULE_14 - Bank B clear returns old contents, keeps faults.
// RULE_15 - Code 1000 clears everything, applies pin byte.
// RULE_16 - Codes 1011/1101/1110 select set, apply pin byte.
// RULE_17 - Set in current second byte, feedback next.
// RULE_18 - Bit 11 set, mode code, pin options byte.
// RULE_19 - Group code 1000 means input pin readback.
// RULE_20 - Status bit five reports ignored command.
// RULE_21 - Field codes 11, 10, 01, 00 per fault.
// RULE_22 - Sixteen-bit frames, decoded at chip-select rise.
`default_nettype none
module sdc_spi_diag_cmd_decoder (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic [9:0] i_parallel_control_pin,
    input wire logic [9:0] i_diag_set,
    input wire logic [19:0] i_diag_code,
    input wire logic [7:0] i_diag_reg_one,
    input wire logic [7:0] i_diag_reg_two,
    input wire logic [7:0] i_diag_reg_three,
    input wire logic [7:0] i_output_pin_feedback,
    input wire logic i_comm_error_clear,
    output logic o_miso,
    output logic o_miso_oe,
    output logic [7:0] o_output_pin_set_byte,
    output logic o_output_pin_set_stb,
    output logic [2:0] o_diag_mode_select,
    output logic o_virtual_diag_clear,
    output logic o_status_comm_error,
    output logic [19:0] o_diag_bank
);
    typedef enum logic [5:0] {
        RESP_ZERO = 6'b000001,
        RESP_PINS = 6'b000010,
        RESP_BANK_A = 6'b000100,
        RESP_BANK_B = 6'b001000,
        RESP_HELD = 6'b010000,
        RESP_FEEDBACK = 6'b100000
    } sdc_resp_t;

    logic [4:0] bit_cnt_r;
    logic [14:0] rx_sh_r;
    logic [15:0] rx_hold_r;
    logic rx_tgl_r;
    logic [1:0] sel_r;
    logic [7:0] first_byte;
    logic [7:0] sel_byte;
    logic [15:0] tx_word_r;
    logic cs_s1_r, cs_s2_r, cs_s3_r, cs_lvl_r, rise_d_r;
    logic cs_fall, cs_rise;
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic [15:0] rx_word_r;
    logic word_new_r;
    logic [9:0] pin_s1_r, pin_s2_r, pin_s3_r, pins_r;
    logic [19:0] diag_r;
    sdc_resp_t resp_r;
    logic [15:0] held_word_r;
    logic [15:0] idle_cnt_r, oc_cnt_r;
    logic clr_a_pend_r, clr_b_pend_r, clr_v_pend_r;
    logic clr_a_now, clr_b_now, oc_busy;
    logic is_ctrl, is_rin, is_dra, is_drb, is_diag_bank_a_clear, is_diag_bank_b_clear, is_dms, is_clr_all, cmd_valid;
    logic bank_a_has_oc, bank_b_has_oc;

    function automatic logic [15:0] with_parity(input logic [14:0] w);
        return {^w, w};
    endfunction : with_parity

    // Link side: count bits and shift in on the falling serial clock; select resets the count.
    always_ff @(negedge i_sclk or posedge i_cs_n or posedge i_reset) begin
        if (i_cs_n || i_reset) begin
            bit_cnt_r <= 5'h00;
        end else if (bit_cnt_r != sdc_pkg::FRAME_BITS) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // Serial data path, no reset needed since only complete frames are handed over.
    always_ff @(negedge i_sclk) begin
        rx_sh_r <= {rx_sh_r[13:0], i_mosi};
    end

    // The sixteenth bit completes a frame; the toggle tells the system side a word waits.
    always_ff @(negedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            rx_hold_r <= sdc_pkg::ZERO_WORD;
            rx_tgl_r <= 1'b0;
        end else if (bit_cnt_r == sdc_pkg::LAST_BIT) begin // RULE_22
            rx_hold_r <= {rx_sh_r, i_mosi};
            rx_tgl_r <= ~rx_tgl_r;
        end
    end

    // The first byte decides the second byte of the same frame, so it is decoded on the link clock.
    assign first_byte = {rx_sh_r[6:0], i_mosi};
    always_ff @(negedge i_sclk or posedge i_cs_n or posedge i_reset) begin
        if (i_cs_n || i_reset) begin
            sel_r <= 2'h0;
        end else if (bit_cnt_r == sdc_pkg::FIRST_BYTE_LAST && first_byte[6:4] == sdc_pkg::SET_DCC
                     && first_byte[3]) begin // RULE_18
            case (first_byte[2:0])
                sdc_pkg::MODE_SELECT_SET_ONE: sel_r <= 2'h1; // RULE_17
                sdc_pkg::MODE_SELECT_SET_TWO, sdc_pkg::MODE_SELECT_CLEAR_ALL: sel_r <= 2'h2;
                sdc_pkg::MODE_SELECT_SET_THREE: sel_r <= 2'h3;
                default: sel_r <= 2'h0;
            endcase
        end
    end

    // Selected set contents; these sit still during a frame, which makes the read safe.
    always_comb begin
        case (sel_r)
            2'h1: sel_byte = i_diag_reg_one;
            2'h2: sel_byte = i_diag_reg_two;
            2'h3: sel_byte = i_diag_reg_three;
            default: sel_byte = 8'h00;
        endcase
    end

    // Output shifts on the rising serial clock; the answer word was fixed at the select fall.
    always_ff @(posedge i_sclk or posedge i_cs_n or posedge i_reset) begin
        if (i_cs_n || i_reset) begin
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end else begin
            o_miso_oe <= 1'b1;
            if (bit_cnt_r[4]) begin
                o_miso <= 1'b0;
            end else if (bit_cnt_r >= sdc_pkg::SECOND_BYTE_START && sel_r != 2'h0) begin
                o_miso <= sel_byte[3'(sdc_pkg::LAST_BIT - bit_cnt_r)]; // RULE_17
            end else begin
                o_miso <= tx_word_r[4'(sdc_pkg::LAST_BIT - bit_cnt_r)];
            end
        end
    end

    // Select level through three flops; an edge counts once the last two agree.
    assign cs_fall = (cs_s2_r == cs_s3_r) && !cs_s3_r && cs_lvl_r;
    assign cs_rise = (cs_s2_r == cs_s3_r) && cs_s3_r && !cs_lvl_r;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {cs_s1_r, cs_s2_r, cs_s3_r, cs_lvl_r, rise_d_r} <= 5'h1E;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            if (cs_s2_r == cs_s3_r) begin
                cs_lvl_r <= cs_s3_r;
            end
            rise_d_r <= cs_rise; // Lets a late frame toggle land before decode.
        end
    end

    // Input pins pass the same three-flop filter, one copy per pin.
    genvar gp;
    generate
        for (gp = 0; gp < sdc_pkg::PIN_COUNT; gp++) begin : g_pin
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    {pin_s1_r[gp], pin_s2_r[gp], pin_s3_r[gp], pins_r[gp]} <= 4'h0;
                end else begin
                    pin_s1_r[gp] <= i_parallel_control_pin[gp];
                    pin_s2_r[gp] <= pin_s1_r[gp];
                    pin_s3_r[gp] <= pin_s2_r[gp];
                    if (pin_s2_r[gp] == pin_s3_r[gp]) begin
                        pins_r[gp] <= pin_s3_r[gp]; // RULE_03
                    end
                end
            end
        end
    endgenerate

    // Frame toggle crossing; a word taken is consumed by the decode after the select rise.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {tgl_s1_r, tgl_s2_r, tgl_s3_r, word_new_r} <= 4'h0;
            rx_word_r <= sdc_pkg::ZERO_WORD;
        end else begin
            tgl_s1_r <= rx_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            if (tgl_s2_r != tgl_s3_r) begin
                rx_word_r <= rx_hold_r;
                word_new_r <= 1'b1;
            end else if (rise_d_r || cs_fall) begin
                word_new_r <= 1'b0;
            end
        end
    end

    // Command decode; a frame that never reached sixteen bits matches nothing.
    always_comb begin
        is_ctrl = rx_word_r[14:12] == sdc_pkg::SET_CTRL && rx_word_r[11:4] == 8'h00
            && (rx_word_r[3:0] inside {sdc_pkg::GA_NOP, sdc_pkg::GA_SHORT_DIAG, sdc_pkg::GA_SHORT_DIAG_STATUS,
                                       sdc_pkg::GA_PATTERN_CHECK, sdc_pkg::GA_INPUT_PIN_READBACK});
        is_rin = is_ctrl && rx_word_r[3:0] == sdc_pkg::GA_INPUT_PIN_READBACK; // RULE_19
        is_dra = rx_word_r[14:12] == sdc_pkg::SET_DCC && rx_word_r[11:0] == sdc_pkg::DIAG_BANK_A_READ; // RULE_11
        is_drb = rx_word_r[14:12] == sdc_pkg::SET_DCC && rx_word_r[11:0] == sdc_pkg::DIAG_BANK_B_READ; // RULE_12
        is_diag_bank_a_clear = rx_word_r[14:12] == sdc_pkg::SET_DCC && rx_word_r[11:0] == sdc_pkg::DIAG_BANK_A_CLEAR;
        is_diag_bank_b_clear = rx_word_r[14:12] == sdc_pkg::SET_DCC && rx_word_r[11:0] == sdc_pkg::DIAG_BANK_B_CLEAR;
        is_dms = rx_word_r[14:12] == sdc_pkg::SET_DCC && rx_word_r[sdc_pkg::BIT_COMBINED]
            && (rx_word_r[10:8] inside {sdc_pkg::MODE_SELECT_CLEAR_ALL, sdc_pkg::MODE_SELECT_SET_ONE,
                                        sdc_pkg::MODE_SELECT_SET_TWO, sdc_pkg::MODE_SELECT_SET_THREE}); // RULE_18
        is_clr_all = is_dms && rx_word_r[10:8] == sdc_pkg::MODE_SELECT_CLEAR_ALL;
        cmd_valid = word_new_r && (is_ctrl || is_dra || is_drb || is_diag_bank_a_clear || is_diag_bank_b_clear || is_dms);
    end

    // Decide next frame's answer and apply combined pin settings; bad frames only set the zero answer here.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            resp_r <= RESP_ZERO;
            held_word_r <= sdc_pkg::ZERO_WORD;
            o_output_pin_set_byte <= 8'h00;
            o_output_pin_set_stb <= 1'b0;
            o_diag_mode_select <= sdc_pkg::MODE_SELECT_CLEAR_ALL;
        end else begin
            o_output_pin_set_stb <= 1'b0;
            if (rise_d_r) begin
                case (1'b1)
                    !cmd_valid: resp_r <= RESP_ZERO; // RULE_05
                    is_rin: resp_r <= RESP_PINS; // RULE_04
                    is_dra: resp_r <= RESP_BANK_A;
                    is_drb: resp_r <= RESP_BANK_B;
                    is_diag_bank_a_clear: begin
                        resp_r <= RESP_HELD;
                        held_word_r <= with_parity({sdc_pkg::BANK_ANSWER_ID, diag_r[11:0]}); // RULE_13
                    end
                    is_diag_bank_b_clear: begin
                        resp_r <= RESP_HELD;
                        held_word_r <= with_parity({sdc_pkg::BANK_ANSWER_ID, 4'h0, diag_r[19:12]}); // RULE_14
                    end
                    is_dms: begin
                        resp_r <= RESP_FEEDBACK;
                        o_output_pin_set_byte <= rx_word_r[7:0]; // RULE_15 RULE_16
                        o_output_pin_set_stb <= 1'b1;
                        o_diag_mode_select <= rx_word_r[10:8];
                    end
                    default: resp_r <= RESP_ZERO;
                endcase
            end
        end
    end

    // Answer word is fixed at the select fall, so pins and bank reads are as of that moment.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            tx_word_r <= sdc_pkg::ZERO_WORD;
        end else if (cs_fall) begin
            case (resp_r)
                RESP_PINS: tx_word_r <= with_parity({5'h00, pins_r}); // RULE_01 RULE_02
                RESP_BANK_A: tx_word_r <= with_parity({sdc_pkg::BANK_ANSWER_ID, diag_r[11:0]});
                RESP_BANK_B: tx_word_r <= with_parity({sdc_pkg::BANK_ANSWER_ID, 4'h0, diag_r[19:12]});
                RESP_HELD: tx_word_r <= held_word_r;
                RESP_FEEDBACK: tx_word_r <= {i_output_pin_feedback, 8'h00}; // RULE_17
                default: tx_word_r <= sdc_pkg::ZERO_WORD;
            endcase
        end
    end

    // Clears wait out the idle time from the select rise; a second clear restarts the wait.
    assign clr_a_now = clr_a_pend_r && idle_cnt_r == sdc_pkg::CNT_ONE;
    assign clr_b_now = clr_b_pend_r && idle_cnt_r == sdc_pkg::CNT_ONE;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            idle_cnt_r <= sdc_pkg::CNT_ZERO;
            {clr_a_pend_r, clr_b_pend_r, clr_v_pend_r, o_virtual_diag_clear} <= 4'h0;
        end else begin
            o_virtual_diag_clear <= clr_v_pend_r && idle_cnt_r == sdc_pkg::CNT_ONE;
            if (rise_d_r && cmd_valid && (is_diag_bank_a_clear || is_diag_bank_b_clear || is_clr_all)) begin
                idle_cnt_r <= sdc_pkg::DIAG_IDLE_CYC; // RULE_09
                clr_a_pend_r <= clr_a_pend_r || is_diag_bank_a_clear || is_clr_all;
                clr_b_pend_r <= clr_b_pend_r || is_diag_bank_b_clear || is_clr_all;
                clr_v_pend_r <= clr_v_pend_r || is_clr_all;
            end else if (idle_cnt_r != sdc_pkg::CNT_ZERO) begin
                idle_cnt_r <= idle_cnt_r - sdc_pkg::CNT_ONE;
                if (idle_cnt_r == sdc_pkg::CNT_ONE) begin
                    {clr_a_pend_r, clr_b_pend_r, clr_v_pend_r} <= 3'h0;
                end
            end
        end
    end

    // Overcurrent holdoff starts when a read frame carrying an overload entry begins.
    always_comb begin
        bank_a_has_oc = 1'b0;
        bank_b_has_oc = 1'b0;
        for (int c = 0; c < sdc_pkg::CHANNELS; c++) begin
            if (diag_r[2*c +: 2] == sdc_pkg::FIELD_OVERLOAD) begin
                if (c < sdc_pkg::BANK_A_CHANNELS) begin
                    bank_a_has_oc = 1'b1;
                end else begin
                    bank_b_has_oc = 1'b1;
                end
            end
        end
    end
    assign oc_busy = oc_cnt_r != sdc_pkg::CNT_ZERO;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            oc_cnt_r <= sdc_pkg::CNT_ZERO;
        end else if (cs_fall && ((resp_r == RESP_BANK_A && bank_a_has_oc) || (resp_r == RESP_BANK_B && bank_b_has_oc))) begin
            oc_cnt_r <= sdc_pkg::OC_HOLDOFF_CYC; // RULE_10
        end else if (oc_busy) begin
            oc_cnt_r <= oc_cnt_r - sdc_pkg::CNT_ONE;
        end
    end

    // One field per channel; a fault arriving with the clear wins, so nothing is lost.
    genvar gc;
    generate
        for (gc = 0; gc < sdc_pkg::CHANNELS; gc++) begin : g_chan
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    diag_r[2*gc +: 2] <= sdc_pkg::FIELD_NO_ERROR; // RULE_21
                end else if (i_diag_set[gc]) begin
                    diag_r[2*gc +: 2] <= i_diag_code[2*gc +: 2]; // RULE_06
                end else if ((gc < sdc_pkg::BANK_A_CHANNELS ? clr_a_now : clr_b_now)
                             && !(oc_busy && diag_r[2*gc +: 2] == sdc_pkg::FIELD_OVERLOAD)) begin
                    diag_r[2*gc +: 2] <= sdc_pkg::FIELD_NO_ERROR; // RULE_08 RULE_10
                end
            end
        end
    endgenerate
    assign o_diag_bank = diag_r;

    // Sticky communication error; a bad frame in the clearing cycle still sets it.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_status_comm_error <= 1'b0;
        end else if (rise_d_r && !cmd_valid) begin
            o_status_comm_error <= 1'b1; // RULE_05 RULE_20
        end else if (i_comm_error_clear) begin
            o_status_comm_error <= 1'b0;
        end
    end

    localparam int AST_IDLE_MAX = int'(sdc_pkg::DIAG_IDLE_CYC);
    sequence s_bank_a_frame;
        resp_r == RESP_BANK_A && cs_fall;
    endsequence
    sequence s_clear_cmd;
        rise_d_r && cmd_valid && is_diag_bank_a_clear;
    endsequence

    AST_PIN_READBACK: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_01
        resp_r == RESP_PINS && cs_fall |=> tx_word_r[14:10] == 5'h00 && tx_word_r[9:0] == $past(pins_r)
        && tx_word_r[15] == ^tx_word_r[14:0]) else $error("pin readback word wrong");
    AST_BAD_FRAME: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_05
        rise_d_r && !cmd_valid |=> o_status_comm_error && $stable(o_output_pin_set_byte)
        && !o_output_pin_set_stb) else $error("bad frame not ignored");
    AST_CLEAR_DELAY: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_09
        s_clear_cmd |=> !clr_a_now [*2] ##[1:AST_IDLE_MAX] clr_a_now) else $error("clear timing wrong");
    AST_CLEAR_BANK: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_08
        clr_a_now && !oc_busy && i_diag_set == 10'h000 |=> diag_r[11:0] == 12'hFFF)
        else $error("bank A not fully cleared");
    AST_READ_KEEPS: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_07
        s_bank_a_frame and (!clr_a_now && !clr_b_now && i_diag_set == 10'h000) |=> $stable(diag_r))
        else $error("read changed bank");
    AST_FAULT_LATCH: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_06
        i_diag_set[0] |=> diag_r[1:0] == $past(i_diag_code[1:0])) else $error("fault not latched");
    AST_OC_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_10
        oc_busy && clr_a_now && diag_r[1:0] == sdc_pkg::FIELD_OVERLOAD && !i_diag_set[0]
        |=> diag_r[1:0] == sdc_pkg::FIELD_OVERLOAD) else $error("overcurrent cleared early");
    AST_OPS_APPLY: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_16
        rise_d_r && cmd_valid && is_dms |=> o_output_pin_set_stb
        && o_output_pin_set_byte == $past(rx_word_r[7:0])) else $error("pin byte not applied");
    AST_BANK_A_WORD: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RULE_11
        s_bank_a_frame |=> tx_word_r[11:0] == $past(diag_r[11:0])) else $error("bank A answer wrong");
endmodule : sdc_spi_diag_cmd_decoder
`default_nettype wire

//--- verification/sdc_host_model.sv
// Host side model: serial master that frames one 16-bit word at a time.
`default_nettype none
module sdc_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Serial clock stands low and select stays high outside frames.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // One frame, data set on the rising and answer taken on the falling serial edge.
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        o_cs_n = 1'b0;
        #48;
        for (int b = 15; b >= 0; b--) begin
            o_sclk = 1'b1;
            o_mosi = cmd[b];
            #7.5;
            o_sclk = 1'b0;
            rsp[b] = i_miso;
            #7.5;
        end
        #40;
        o_cs_n = 1'b1;
        // Released line flips, so a stale bit is never mistaken for data.
        o_mosi = ~o_mosi;
        #64;
    endtask : xfer
endmodule : sdc_host_model
`default_nettype wire

//--- verification/tb_sdc_spi_diag_cmd_decoder.sv
// Self-checking bench for the serial diagnosis command decoder.
`default_nettype none
module tb_sdc_spi_diag_cmd_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys = 1'b0, i_reset = 1'b0, ce_clr = 1'b0, sclk, cs_n, mosi, miso, oe, stb, vclr, cerr;
    logic [9:0] pins = '0, dset = '0, pexp;
    logic [19:0] dcode = '0, bank;
    logic [7:0] r1 = '0, r2 = '0, r3 = '0, fb = '0, psb, ob, sel;
    logic [2:0] msel;
    logic [15:0] rsp;
    logic [3:0] cd [4] = '{4'h8, 4'hB, 4'hD, 4'hE};
    int failures, compares, stb_cnt, vclr_cnt, oe_bad;
    sdc_spi_diag_cmd_decoder sdc_spi_diag_cmd_decoder_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_parallel_control_pin(pins), .i_diag_set(dset),
        .i_diag_code(dcode), .i_diag_reg_one(r1), .i_diag_reg_two(r2), .i_diag_reg_three(r3),
        .i_output_pin_feedback(fb), .i_comm_error_clear(ce_clr), .o_miso(miso), .o_miso_oe(oe),
        .o_output_pin_set_byte(psb), .o_output_pin_set_stb(stb), .o_diag_mode_select(msel),
        .o_virtual_diag_clear(vclr), .o_status_comm_error(cerr), .o_diag_bank(bank));
    sdc_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
    // System clock, 8 ns period.
    initial begin
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    // Pulse counters for the one-cycle strobes.
    always @(posedge i_clk_sys) begin
        stb_cnt += (stb === 1'b1);
        vclr_cnt += (vclr === 1'b1);
        oe_bad += (cs_n === 1'b1 && oe !== 1'b0);
    end
    // The output enable must stand high at every sampling edge inside a frame.
    always @(negedge sclk) begin
        oe_bad += (cs_n === 1'b0 && oe !== 1'b1);
    end
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [15:0] par(input logic [14:0] w);
        return {^w, w};
    endfunction : par
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc
    // Frame starts off the system edge; decode needs about five cycles after select rise.
    task automatic frame(input logic [15:0] cmd);
        #3.3;
        host.xfer(cmd, rsp);
        cyc(10);
    endtask : frame
    task automatic fault(input int ch, input logic [1:0] code);
        dset <= 10'h001 << ch;
        dcode <= 20'(code) << (2 * ch);
        cyc(1);
        dset <= '0;
        cyc(2);
    endtask : fault
    task automatic stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // Watchdog: a hang counts as a mismatch.
    initial begin
        cyc(100000);
        failures++;
        stop_test();
    end
    // Main sequence.
    initial begin
        // Reset rises at time zero so the link-side flops see an edge to reset on.
        i_reset <= 1'b1;
        void'($urandom(32'hbcf5_dd9d));
        cyc(5);
        i_reset <= 1'b0;
        cyc(6);
        check("bank reset", bank, 20'hF_FFFF);
        pins <= 10'($urandom());
        frame(16'h0008);
        pexp = 10'($urandom());
        pins <= pexp;
        cyc(2);
        frame(16'h0000);
        check("pin readback", rsp, par({5'h00, pexp}));
        fault(0, 2'h2);
        fault(7, 2'h1);
        check("bank latch", bank, 20'hF_7FFE);
        frame(16'h1600);
        frame(16'h0000);
        check("bank b read", rsp, par({3'h1, 4'h0, 8'hF7}));
        // Clear right after a read: the overload entry must survive the holdoff.
        frame(16'h1500);
        frame(16'h1100);
        check("bank a read", rsp, par({3'h1, 12'hFFE}));
        frame(16'h0000);
        check("bank a clear answer", rsp, par({3'h1, 12'hFFE}));
        cyc(260);
        check("overload held", bank, 20'hF_7FFE);
        cyc(700);
        frame(16'h1100);
        check("clear waits", bank, 20'hF_7FFE);
        cyc(250);
        check("bank a cleared", bank, 20'hF_7FFF);
        frame(16'h1200);
        cyc(250);
        check("bank b cleared", bank, 20'hF_FFFF);
        frame(16'h1300);
        check("comm error", cerr, 20'h0_0001);
        check("bank ignored", bank, 20'hF_FFFF);
        ce_clr <= 1'b1;
        cyc(1);
        ce_clr <= 1'b0;
        cyc(2);
        check("comm error clear", cerr, 20'h0_0000);
        frame(16'h0004);
        check("group code valid", cerr, 20'h0_0000);
        fault(2, 2'h1);
        r1 <= 8'($urandom());
        r2 <= 8'($urandom());
        r3 <= 8'($urandom());
        fb <= 8'($urandom());
        cyc(1);
        for (int i = 0; i < 4; i++) begin
            ob = 8'h01 << ($urandom() % 8);
            sel = (cd[i] == 4'hB) ? r1 : (cd[i] == 4'hE) ? r3 : r2;
            frame({4'h1, cd[i], ob});
            check("selected set", rsp[7:0], sel);
            if (i > 0) check("feedback", rsp[15:8], fb);
            check("pin byte", psb, ob);
            check("mode", msel, cd[i][2:0]);
        end
        frame(16'h0000);
        check("last feedback", rsp[15:8], fb);
        cyc(260);
        check("clear all", bank, 20'hF_FFFF);
        check("strobes", stb_cnt, 4);
        check("virtual clear", vclr_cnt, 1);
        check("miso enable", oe_bad, 0);
        stop_test();
    end
endmodule : tb_sdc_spi_diag_cmd_decoder
`default_nettype wire
